// File: common/nfp_defs.vh
// Constants for the NAND feature and protection host controller
`ifndef NFP_DEFS_VH
`define NFP_DEFS_VH

// Software register offsets (byte addresses)
`define NFP_REG_CTRL 8'h00
`define NFP_REG_FADDR 8'h04
`define NFP_REG_WDATA 8'h08
`define NFP_REG_RDATA 8'h0c
`define NFP_REG_STATUS 8'h10

// Control register fields
`define NFP_CTRL_GO 0
`define NFP_CTRL_OP_LO 1
`define NFP_CTRL_OP_HI 2
`define NFP_CTRL_POLL 3
`define NFP_CTRL_WP_EN 4

// Operation codes
`define NFP_OP_GET 2'h1
`define NFP_OP_SET 2'h2
`define NFP_OP_STAT 2'h3

// Status register fields
`define NFP_ST_BUSY 0
`define NFP_ST_READY 1
`define NFP_ST_DONE 2
`define NFP_ST_ERR 3
`define NFP_ST_STR_LO 4
`define NFP_ST_STR_HI 5
`define NFP_ST_NSTAT_LO 8
`define NFP_ST_NSTAT_HI 15

// Device command codes
`define NFP_CMD_GET_FEAT 8'hee
`define NFP_CMD_SET_FEAT 8'hef
`define NFP_CMD_STATUS 8'h70
`define NFP_CMD_READ 8'h00

// Feature address and layout
`define NFP_FA_PULLDOWN 8'h81
`define NFP_FADDR_RST 8'h81
`define NFP_PULLDOWN_MASK 8'h03
`define NFP_RESERVED_BYTE 8'h00
`define NFP_NSTAT_RDY_BIT 6

// Times in ns, clock period in ns
`define NFP_CLK_PERIOD_NS 100
`define NFP_FEATURE_BUSY_TIME_NS 1000
`define NFP_PROTECT_SETUP_TIME_NS 100
`define NFP_WE_TO_BUSY_NS 100
`define NFP_POWERUP_NS 1000000

`endif

// File: src/nfp_host_ctrl.v
// Host controller that reads and writes NAND feature parameters over the pin interface
`include "nfp_defs.vh"
`default_nettype none

module nfp_host_ctrl #(
  parameter PWRUP_CYCLES = `NFP_POWERUP_NS / `NFP_CLK_PERIOD_NS
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg ce_n_o,
  output reg cle_o,
  output reg ale_o,
  output reg we_n_o,
  output reg read_strobe_n_o,
  output reg wp_n_o,
  output reg [7:0] io_o,
  output reg io_oe_o,
  input wire [7:0] io_i,
  input wire ready_busy_n_i
);

  localparam [31:0] WW_CYC = (`NFP_PROTECT_SETUP_TIME_NS + `NFP_CLK_PERIOD_NS - 1) /
                             `NFP_CLK_PERIOD_NS;
  localparam [31:0] WB_CYC = (`NFP_WE_TO_BUSY_NS + `NFP_CLK_PERIOD_NS - 1) / `NFP_CLK_PERIOD_NS;
  localparam [31:0] FEAT_CYC = `NFP_FEATURE_BUSY_TIME_NS / `NFP_CLK_PERIOD_NS;
  localparam [31:0] BUSY_CYC = WB_CYC + FEAT_CYC;
  localparam [31:0] PWR_CYC = PWRUP_CYCLES;
  localparam [15:0] WW_CNT = WW_CYC[15:0];
  localparam [15:0] WB_CNT = WB_CYC[15:0];
  localparam [15:0] BUSY_LIMIT = BUSY_CYC[15:0];
  localparam [15:0] PWR_CNT = PWR_CYC[15:0];

  localparam [9:0] S_PWR = 10'h001;
  localparam [9:0] S_IDLE = 10'h002;
  localparam [9:0] S_WP = 10'h004;
  localparam [9:0] S_NEXT = 10'h008;
  localparam [9:0] S_WLO = 10'h010;
  localparam [9:0] S_WHI = 10'h020;
  localparam [9:0] S_GAP = 10'h040;
  localparam [9:0] S_BUSY = 10'h080;
  localparam [9:0] S_RLO = 10'h100;
  localparam [9:0] S_RHI = 10'h200;

  reg [9:0] state_reg;
  reg [3:0] step_reg;
  reg [1:0] op_reg;
  reg [15:0] cnt_reg;
  reg [7:0] faddr_reg;
  reg [31:0] wdata_reg;
  reg [31:0] rdata_reg;
  reg [7:0] nstat_reg;
  reg [1:0] strength_reg;
  reg wp_en_reg;
  reg poll_reg;
  reg done_reg;
  reg err_reg;

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // A write lands at the edge where the master sees ack
  wire wb_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
  wire [1:0] bsel = step_reg[1:0] + 2'h2;
  wire is_pd = (faddr_reg == `NFP_FA_PULLDOWN);
  wire [7:0] wbyte = wdata_reg[8 * bsel +: 8];
  wire [7:0] set_byte = ~is_pd ? wbyte :
                        (bsel == 2'h0) ? (wbyte & `NFP_PULLDOWN_MASK) : `NFP_RESERVED_BYTE;
  wire [31:0] status_word = {16'h0000, nstat_reg, 2'h0, strength_reg, err_reg, done_reg,
                             (state_reg != S_PWR), ~(state_reg == S_IDLE || state_reg == S_PWR)};

  // Starts one write cycle with a latch kind and a byte
  task issue;
    input cmd;
    input adr;
    input [7:0] val;
    begin
      cle_o <= cmd;
      ale_o <= adr;
      io_o <= val;
      io_oe_o <= 1'b1;
      state_reg <= S_WLO;
    end
  endtask

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == `NFP_REG_CTRL) begin
          wb_dat_o <= {27'h0000000, wp_en_reg, poll_reg, op_reg, 1'b0};
        end else if (wb_adr_i == `NFP_REG_FADDR) begin
          wb_dat_o <= {24'h000000, faddr_reg};
        end else if (wb_adr_i == `NFP_REG_WDATA) begin
          wb_dat_o <= wdata_reg;
        end else if (wb_adr_i == `NFP_REG_RDATA) begin
          wb_dat_o <= rdata_reg;
        end else if (wb_adr_i == `NFP_REG_STATUS) begin
          wb_dat_o <= status_word;
        end
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_PWR;
      step_reg <= 4'h0;
      op_reg <= 2'h0;
      cnt_reg <= 16'h0000;
      faddr_reg <= `NFP_FADDR_RST;
      wdata_reg <= 32'h00000000;
      rdata_reg <= 32'h00000000;
      nstat_reg <= 8'h00;
      strength_reg <= 2'h0;
      wp_en_reg <= 1'b0;
      poll_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      ce_n_o <= 1'b1;
      cle_o <= 1'b0;
      ale_o <= 1'b0;
      we_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
      wp_n_o <= 1'b0;
      io_o <= 8'h00;
      io_oe_o <= 1'b0;
    end else begin
      if (wb_wr && wb_adr_i == `NFP_REG_FADDR && wb_sel_i[0]) begin
        faddr_reg <= wb_dat_i[7:0];
      end
      if (wb_wr && wb_adr_i == `NFP_REG_WDATA) begin
        if (wb_sel_i[0]) wdata_reg[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) wdata_reg[15:8] <= wb_dat_i[15:8];
        if (wb_sel_i[2]) wdata_reg[23:16] <= wb_dat_i[23:16];
        if (wb_sel_i[3]) wdata_reg[31:24] <= wb_dat_i[31:24];
      end
      if (wb_wr && wb_adr_i == `NFP_REG_CTRL && wb_sel_i[0]) begin
        wp_en_reg <= wb_dat_i[`NFP_CTRL_WP_EN];
        poll_reg <= wb_dat_i[`NFP_CTRL_POLL];
        if (wb_dat_i[`NFP_CTRL_GO]) begin
          done_reg <= 1'b0;
          err_reg <= 1'b0;
        end
      end
      case (state_reg)
        S_PWR: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg >= PWR_CNT) begin
            state_reg <= S_IDLE;
          end
        end
        S_IDLE: begin
          // protect pin moves only between operations
          // pin level gates program and erase at the device
          wp_n_o <= wp_en_reg;
          ce_n_o <= 1'b1;
          if (wb_wr && wb_adr_i == `NFP_REG_CTRL && wb_sel_i[0] && wb_dat_i[`NFP_CTRL_GO] &&
              wb_dat_i[`NFP_CTRL_OP_HI:`NFP_CTRL_OP_LO] != 2'h0) begin
            // New protect level goes out ahead of the setup wait
            wp_n_o <= wb_dat_i[`NFP_CTRL_WP_EN];
            op_reg <= wb_dat_i[`NFP_CTRL_OP_HI:`NFP_CTRL_OP_LO];
            step_reg <= 4'h0;
            cnt_reg <= 16'h0000;
            state_reg <= S_WP;
          end
        end
        S_WP: begin
          // Protect setup time before the first command
          ce_n_o <= 1'b0;
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg + 16'h0001 >= WW_CNT) begin
            state_reg <= S_NEXT;
          end
        end
        S_NEXT: begin
          cnt_reg <= 16'h0000;
          if (op_reg == `NFP_OP_GET) begin
            if (step_reg == 4'h0) begin
              issue(1'b1, 1'b0, `NFP_CMD_GET_FEAT);
            end else if (step_reg == 4'h1) begin
              issue(1'b0, 1'b1, faddr_reg);
            end else if (step_reg == 4'h2) begin
              state_reg <= S_BUSY;
            end else if (step_reg == 4'h3) begin
              if (poll_reg) begin
                issue(1'b1, 1'b0, `NFP_CMD_STATUS);
              end else begin
                step_reg <= 4'h6;
              end
            end else if (step_reg == 4'h4) begin
              state_reg <= S_RLO;
            end else if (step_reg == 4'h5) begin
              issue(1'b1, 1'b0, `NFP_CMD_READ);
            end else if (step_reg <= 4'h9) begin
              state_reg <= S_RLO;
            end else begin
              done_reg <= 1'b1;
              state_reg <= S_IDLE;
            end
          end else if (op_reg == `NFP_OP_SET) begin
            if (step_reg == 4'h0) begin
              issue(1'b1, 1'b0, `NFP_CMD_SET_FEAT);
            end else if (step_reg == 4'h1) begin
              issue(1'b0, 1'b1, faddr_reg);
            end else if (step_reg <= 4'h5) begin
              issue(1'b0, 1'b0, set_byte);
            end else if (step_reg == 4'h6) begin
              state_reg <= S_BUSY;
            end else begin
              if (is_pd && !err_reg) strength_reg <= wdata_reg[1:0];
              done_reg <= 1'b1;
              state_reg <= S_IDLE;
            end
          end else begin
            if (step_reg == 4'h0) begin
              issue(1'b1, 1'b0, `NFP_CMD_STATUS);
            end else if (step_reg == 4'h1) begin
              state_reg <= S_RLO;
            end else begin
              done_reg <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
        end
        S_WLO: begin
          we_n_o <= 1'b0;
          state_reg <= S_WHI;
        end
        S_WHI: begin
          // byte latched on this rising strobe
          we_n_o <= 1'b1;
          state_reg <= S_GAP;
        end
        S_GAP: begin
          cle_o <= 1'b0;
          ale_o <= 1'b0;
          io_oe_o <= 1'b0;
          step_reg <= step_reg + 4'h1;
          state_reg <= S_NEXT;
        end
        S_BUSY: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg >= WB_CNT && ready_busy_n_i) begin
            step_reg <= step_reg + 4'h1;
            state_reg <= S_NEXT;
          end else if (cnt_reg >= BUSY_LIMIT) begin
            err_reg <= 1'b1;
            done_reg <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        S_RLO: begin
          read_strobe_n_o <= 1'b0;
          state_reg <= S_RHI;
        end
        S_RHI: begin
          read_strobe_n_o <= 1'b1;
          if (op_reg == `NFP_OP_GET && step_reg >= 4'h6) begin
            rdata_reg[8 * bsel +: 8] <= io_i;
            // strength decoded from P1 bits 1:0
            if (bsel == 2'h0 && is_pd) strength_reg <= io_i[1:0];
            step_reg <= step_reg + 4'h1;
          end else begin
            nstat_reg <= io_i;
            if (op_reg != `NFP_OP_GET || io_i[`NFP_NSTAT_RDY_BIT]) begin
              step_reg <= step_reg + 4'h1;
            end
          end
          state_reg <= S_NEXT;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// File: testbench/nfp_nand_model.sv
// Behavioural NAND device answering feature, status and read commands
`default_nettype none
module nfp_nand_model (
  input wire logic clk_i,
  input wire logic ce_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic re_n_i,
  input wire logic wp_n_i,
  input wire logic [7:0] io_i,
  input wire logic [7:0] busy_len_i,
  output logic [7:0] io_o,
  output logic ready_busy_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cmd;
  logic [7:0] busy_pulldown_strength;
  logic stat_mode;
  int cnt;
  int idx;
  initial begin
    busy_pulldown_strength = 8'h00;
    cmd = 8'h00;
    stat_mode = 0;
    cnt = 0;
    idx = 0;
    io_o = 8'ha5;
  end
  assign ready_busy_n_o = (cnt == 0);
  always @(posedge clk_i) if (cnt > 0) cnt <= cnt - 1;
  always @(posedge we_n_i) if (!ce_n_i) begin
    if (cle_i) begin
      cmd = io_i;
      idx = 0;
      stat_mode = (io_i == 8'h70);
    end else if (ale_i) begin
      idx = 0;
      if (cmd == 8'hee) cnt <= busy_len_i;
    end else if (cmd == 8'hef) begin
      if (idx == 0) busy_pulldown_strength = io_i & 8'h03;
      idx++;
      if (idx == 4) cnt <= busy_len_i;
    end
  end
  // status bit 7 reports the protect pin level
  always @(negedge re_n_i) begin
    io_o <= stat_mode ? {wp_n_i, ready_busy_n_o, ready_busy_n_o, 5'h00} :
      (idx == 0 ? busy_pulldown_strength : 8'h00);
    idx++;
  end
  // Released bus shows a changed pattern
  always @(posedge re_n_i) io_o <= ~io_o;
endmodule
`default_nettype wire

// File: testbench/nfp_host_ctrl_sva.sv
// Assertions on the NAND feature host controller pins and bus
`default_nettype none
module nfp_host_ctrl_sva #(
  parameter PWRUP_CYCLES = 10000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic ce_n_o,
  input wire logic cle_o,
  input wire logic ale_o,
  input wire logic we_n_o,
  input wire logic read_strobe_n_o,
  input wire logic wp_n_o,
  input wire logic [7:0] io_o,
  input wire logic io_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int up_cnt;
  always @(posedge clk_i) begin
    up_cnt <= rst_i ? 0 : (up_cnt < PWRUP_CYCLES ? up_cnt + 1 : up_cnt);
  end
  sequence s_wr;
    !we_n_o && io_oe_o;
  endsequence
  sequence s_cmd_ee;
    s_wr and cle_o && io_o == 8'hee;
  endsequence
  sequence s_cmd_ef;
    s_wr and cle_o && io_o == 8'hef;
  endsequence
  sequence s_addr;
    s_wr and ale_o;
  endsequence
  sequence s_data(logic [7:0] m);
    s_wr and !cle_o && !ale_o && (io_o & m) == 8'h00;
  endsequence
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle");
  a_get_addr: assert property (s_cmd_ee |-> ##4 s_addr)
    else $error("get command without address");
  a_set_four: assert property (
    s_cmd_ef ##4 (s_addr and io_o == 8'h81) |->
    ##4 s_data(8'hfc) ##4 s_data(8'hff) ##4 s_data(8'hff) ##4 s_data(8'hff))
    else $error("set parameters wrong");
  a_we_one: assert property ($fell(we_n_o) |=> we_n_o)
    else $error("write strobe too long");
  a_strobe_one: assert property (!read_strobe_n_o |=> read_strobe_n_o && !io_oe_o)
    else $error("read strobe too long");
  a_wp_steady: assert property (!ce_n_o && !$past(ce_n_o) |-> $stable(wp_n_o))
    else $error("write protect moved in operation");
  a_power_wait: assert property (up_cnt < PWRUP_CYCLES |-> ce_n_o && we_n_o)
    else $error("command before power-up wait");
  a_drive_data: assert property ($fell(we_n_o) |-> io_oe_o && $stable(io_o))
    else $error("data not set before write strobe");
  a_ce_active: assert property (!we_n_o || !read_strobe_n_o |-> !ce_n_o)
    else $error("strobe without chip enable");
endmodule
bind nfp_host_ctrl nfp_host_ctrl_sva #(.PWRUP_CYCLES(PWRUP_CYCLES)) u_sva (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ce_n_o, .cle_o, .ale_o, .we_n_o, .read_strobe_n_o,
  .wp_n_o, .io_o, .io_oe_o);
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the NAND feature host controller
`include "nfp_defs.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o, ce_n, cle, ale, we_n, re_n, wp_n;
  logic io_oe, rb_n;
  logic [7:0] wb_adr, io_o, io_i, busy_len;
  logic [31:0] wb_dat, wb_dat_o, q, d;
  logic [63:0] nq[$];
  logic [63:0] note;
  int errors = 0, checked = 0, cyc = 0, seed = 32'hb557;
  nfp_host_ctrl #(.PWRUP_CYCLES(20)) uut (.clk_i, .rst_i, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o,
    .wb_ack_o, .ce_n_o(ce_n), .cle_o(cle), .ale_o(ale), .we_n_o(we_n),
    .read_strobe_n_o(re_n), .wp_n_o(wp_n), .io_o, .io_oe_o(io_oe), .io_i, .ready_busy_n_i(rb_n));
  nfp_nand_model dev (.clk_i, .ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
    .re_n_i(re_n), .wp_n_i(wp_n), .io_i(io_o), .busy_len_i(busy_len), .io_o(io_i),
    .ready_busy_n_o(rb_n));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One classic cycle; a read notes {mask, expected}
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dw,
    input logic [63:0] n);
    int k;
    k = 0;
    if (!we) nq.push_back(n);
    wb_cyc <= 1;
    wb_stb <= 1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= dw;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k == 50) errors++;
    q = wb_dat_o;
    wb_cyc <= 0;
    wb_stb <= 0;
    @(posedge clk_i);
  endtask
  task automatic run(input logic [7:0] ctrl);
    int k;
    k = 0;
    wb(1, `NFP_REG_CTRL, {24'h0, ctrl}, 0);
    q = 0;
    while (q[`NFP_ST_DONE] !== 1'b1 && k < 100) begin
      wb(0, `NFP_REG_STATUS, 0, 0);
      k++;
    end
    if (k == 100) errors++;
  endtask
  initial begin
    clk_i = 0;
    forever #50 clk_i = ~clk_i;
  end
  // Result watcher and hang limit
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
    if (wb_ack_o === 1'b1 && wb_we === 1'b0 && nq.size() > 0) begin
      note = nq.pop_front();
      if (note[63:32] != 0) check(wb_dat_o & note[63:32], note[31:0]);
    end
  end
  initial begin
    rst_i = 1;
    wb_cyc = 0;
    wb_stb = 0;
    wb_we = 0;
    wb_adr = 0;
    wb_dat = 0;
    busy_len = 8'h08;
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, `NFP_REG_STATUS, 0, {32'h2, 32'h0});
    repeat (25) @(posedge clk_i);
    wb(0, `NFP_REG_STATUS, 0, {32'h3f, 32'h2});
    wb(0, `NFP_REG_FADDR, 0, {32'hff, 32'h81});
    run(8'h03);
    wb(0, `NFP_REG_RDATA, 0, {32'hffffffff, 32'h0});
    $display("test defaults done");
    for (int v = 3; v >= 0; v--) begin
      d = $random(seed);
      wb(1, `NFP_REG_WDATA, {d[31:2], v[1:0]}, 0);
      run(8'h15);
      check({31'h0, wp_n}, 32'h1);
      wb(0, `NFP_REG_STATUS, 0, {32'h3f, 26'h0, v[1:0], 4'h6});
      run(8'h0b);
      wb(0, `NFP_REG_RDATA, 0, {32'hffffffff, 30'h0, v[1:0]});
    end
    $display("test set and get done");
    run(8'h07);
    wb(0, `NFP_REG_STATUS, 0, {32'hff0f, 32'h6006});
    run(8'h17);
    wb(0, `NFP_REG_STATUS, 0, {32'hff0f, 32'he006});
    busy_len = 8'h28;
    run(8'h03);
    wb(0, `NFP_REG_STATUS, 0, {32'hf, 32'he});
    busy_len = 8'h08;
    repeat (45) @(posedge clk_i);
    wb(1, 8'h14, 32'hffffffff, 0);
    wb(0, 8'h14, 0, {32'hffffffff, 32'h0});
    $display("test status timeout unmapped done");
    wrap_up();
  end
endmodule
`default_nettype wire
